// File: verilog/mapped_space_params.svh
/*
 * Constants of the mapped space decoder: register offsets, reset values,
 * field positions and masks.
 * Assumes nothing of its surroundings; included by bare name.
 */
`ifndef MAPPED_SPACE_PARAMS_SVH
`define MAPPED_SPACE_PARAMS_SVH

// Special function register offsets on the core's register port
`define OFS_MEM_IF_CONTROL 11'h495
`define OFS_REGSPACE_BASE_LOW 11'h496
`define OFS_REGSPACE_BASE_HIGH 11'h497

// Offsets inside the mapped register window
`define OFS_BUFFER_RAM_BASE 12'h290
`define OFS_BUFFER_SEGMENT 12'h291
`define MSG_OBJ_LIMIT 12'h200

// Reset values
`define RST_MEM_IF_CONTROL 8'h00
`define RST_REGSPACE_BASE_LOW 8'hf0
`define RST_REGSPACE_BASE_HIGH 8'h0f
`define RST_BUFFER_RAM_BASE 8'hfe
`define RST_BUFFER_SEGMENT 8'hff

// Writable bits
`define MASK_MEM_IF_CONTROL 8'h18
`define MASK_REGSPACE_BASE_LOW 8'hf1

// Field positions
`define BIT_REGSPACE_ENABLE 0
`define BIT_BUFFER_RAM_ENABLE 0
`define BIT_WAIT_STATE_DISABLE 4
`define BIT_EXTERNAL_ACCESS_DISABLE 3

`endif

// File: verilog/mapped_space_pkg.sv
/*
 * Types of the mapped space decoder: access states and targets.
 * Assumes nothing of its surroundings; uses no constant of the header.
 */
package mapped_space_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } access_state_t;

    typedef enum logic [1:0] {
        TGT_REG = 2'b00,
        TGT_MMR = 2'b01,
        TGT_MESSAGE_BUFFER_RAM = 2'b10,
        TGT_EXT = 2'b11
    } target_t;

endpackage

// File: verilog/mapped_space_decoder.sv
/*
 * Address decoder and router of the memory interface unit: arbitrates
 * core and DMA data accesses and sends each to the mapped register bus,
 * the on-chip message buffer RAM, or external memory.
 * Assumes requesters hold a request stable until its ack, and that the
 * mapped register bus and external memory answer with one-cycle acks.
 */
// Function
// - Arbitrate core and DMA, reach registers, RAM
// - Programmable cycle length, waits, 16-bit bus
// - Register window is 4 KB, 4 KB aligned
// - Register window relocatable across 16 MB
// - Upper twelve bits match high, low[7:4]
// - Bases reset to 0Fh, F0h, disabled
// - Low base bit 0 enables window
// - First 512 window bytes are message objects
// - 512-byte buffer RAM, 512-byte aligned base
// - Upper fifteen bits match segment, base[7:1]
// - Buffer base bit 0 enables RAM
// - Buffer base resets FEh, segment FFh
// - Segment supplies upper bits of buffers
`timescale 1ns/1ps
`include "mapped_space_params.svh"

module mapped_space_decoder
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Core data access
    input wire logic core_req,
    input wire logic core_burst,
    input wire logic [23:0] core_addr,
    input wire logic core_we,
    input wire logic [1:0] core_be,
    input wire logic [15:0] core_wdata,
    output logic core_ack,
    output logic [15:0] core_rdata,
    // DMA data access
    input wire logic dma_req,
    input wire logic [23:0] dma_addr,
    input wire logic dma_we,
    input wire logic [1:0] dma_be,
    input wire logic [15:0] dma_wdata,
    output logic dma_ack,
    output logic [15:0] dma_rdata,
    // Core special function register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [10:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Mapped register bus
    output logic mmr_req,
    output logic [11:0] mmr_addr,
    output logic mmr_we,
    output logic [1:0] mmr_be,
    output logic [15:0] mmr_wdata,
    output logic mmr_msg_obj,
    output logic [4:0] mmr_obj_index,
    input wire logic mmr_ack,
    input wire logic [15:0] mmr_rdata,
    // External memory
    input wire logic [3:0] ext_cycles,
    output logic ext_req,
    output logic [19:1] ext_addr,
    output logic ext_we,
    output logic [1:0] ext_be,
    output logic [15:0] ext_wdata,
    input wire logic ext_ready,
    input wire logic [15:0] ext_rdata
);
    import mapped_space_pkg::*;

    access_state_t st_q, st_d;
    target_t tgt_q, tgt_d;
    logic [7:0] ctl_q, base_low_q, base_high_q, ram_base_q, segment_q;
    logic [7:0] sfr_rdata_q;
    logic [23:0] addr_q;
    logic we_q, who_q, last_dma_q, ack_q;
    logic [1:0] be_q;
    logic [15:0] wdata_q, rdata_q, rdata_d;
    logic [3:0] cnt_q;
    logic [15:0] message_buffer_ram_q [0:255];

    // Alternate between the two masters; a core burst keeps the bus
    wire core_wins = core_req && (!dma_req || core_burst || last_dma_q);
    wire sel_dma = !core_wins && dma_req;
    wire sel_req = core_req || dma_req;
    wire [23:0] sel_addr = sel_dma ? dma_addr : core_addr;

    // Window decode; the 4 KB window base has no low bits, so it
    // is always aligned whatever software writes
    wire regspace_en = base_low_q[`BIT_REGSPACE_ENABLE];
    wire [11:0] regspace_tag = {base_high_q, base_low_q[7:4]};
    wire mmr_hit = regspace_en && (sel_addr[23:12] == regspace_tag);
    wire ram_en = ram_base_q[`BIT_BUFFER_RAM_ENABLE];
    wire [14:0] ram_tag = {segment_q, ram_base_q[7:1]};
    wire message_buffer_ram_hit = ram_en && (sel_addr[23:9] == ram_tag);
    wire own_reg = ({sel_addr[11:1], 1'b0} == `OFS_BUFFER_RAM_BASE);

    // Register window wins over the buffer RAM if both overlap
    always_comb
    begin
        if (mmr_hit)
            tgt_d = own_reg ? TGT_REG : TGT_MMR;
        else if (message_buffer_ram_hit)
            tgt_d = TGT_MESSAGE_BUFFER_RAM;
        else
            tgt_d = TGT_EXT;
    end

    // Memory interface control fields
    wire wait_state_disable = ctl_q[`BIT_WAIT_STATE_DISABLE];
    wire external_access_disable = ctl_q[`BIT_EXTERNAL_ACCESS_DISABLE];

    // Completion of the access under way
    wire ext_timed = (cnt_q >= ext_cycles);
    wire ext_done = external_access_disable
        || (ext_timed && (wait_state_disable || ext_ready));
    logic done;
    always_comb
    begin
        case (tgt_q)
            TGT_MMR: done = mmr_ack;
            TGT_EXT: done = ext_done;
            default: done = 1'b1;
        endcase
    end
    wire finish = (st_q == ST_BUSY) && done;

    // Access sequencing: take, serve, answer for one cycle
    always_comb
    begin
        case (st_q)
            ST_IDLE: st_d = sel_req ? ST_BUSY : ST_IDLE;
            ST_BUSY: st_d = done ? ST_DONE : ST_BUSY;
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    // Read data of the finishing access
    wire [7:0] message_buffer_ram_idx = addr_q[8:1];
    always_comb
    begin
        case (tgt_q)
            TGT_REG: rdata_d = {segment_q, ram_base_q};
            TGT_MMR: rdata_d = mmr_rdata;
            TGT_MESSAGE_BUFFER_RAM: rdata_d = message_buffer_ram_q[message_buffer_ram_idx];
            default: rdata_d = external_access_disable ? 16'h0000
                : ext_rdata;
        endcase
    end

    // Sequencer and latched request
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= ST_IDLE;
            tgt_q <= TGT_EXT;
            addr_q <= 24'h000000;
            we_q <= 1'b0;
            be_q <= 2'b00;
            wdata_q <= 16'h0000;
            who_q <= 1'b0;
            last_dma_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            if (st_q == ST_IDLE && sel_req)
            begin
                tgt_q <= tgt_d;
                addr_q <= sel_addr;
                we_q <= sel_dma ? dma_we : core_we;
                be_q <= sel_dma ? dma_be : core_be;
                wdata_q <= sel_dma ? dma_wdata : core_wdata;
                who_q <= sel_dma;
                last_dma_q <= sel_dma;
            end
        end
    end

    // Wait-state counter, cleared whenever no access is running
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= 4'h0;
        else if (st_q != ST_BUSY)
            cnt_q <= 4'h0;
        else if (!ext_timed)
            cnt_q <= cnt_q + 4'h1;
    end

    // Answer held in flops for one cycle; read data held until the next read finishes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            ack_q <= finish;
            if (finish && !we_q)
                rdata_q <= rdata_d;
        end
    end

    // Control and base registers on the special function register port
    wire sfr_ctl = (sfr_addr == `OFS_MEM_IF_CONTROL);
    wire sfr_low = (sfr_addr == `OFS_REGSPACE_BASE_LOW);
    wire sfr_high = (sfr_addr == `OFS_REGSPACE_BASE_HIGH);
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctl_q <= `RST_MEM_IF_CONTROL;
            base_low_q <= `RST_REGSPACE_BASE_LOW;
            base_high_q <= `RST_REGSPACE_BASE_HIGH;
        end
        else if (sfr_wr)
        begin
            if (sfr_ctl)
                ctl_q <= sfr_wdata & `MASK_MEM_IF_CONTROL;
            if (sfr_low)
                base_low_q <= sfr_wdata & `MASK_REGSPACE_BASE_LOW;
            if (sfr_high)
                base_high_q <= sfr_wdata;
        end
    end

    // Register port read data; unmapped offsets read zero
    wire [7:0] sfr_mux = sfr_ctl ? ctl_q
        : sfr_low ? base_low_q
        : sfr_high ? base_high_q : 8'h00;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sfr_rdata_q <= 8'h00;
        else if (sfr_rd)
            sfr_rdata_q <= sfr_mux;
    end

    // Buffer RAM base and segment, low and high byte of one word
    wire reg_wr = finish && we_q && (tgt_q == TGT_REG);
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ram_base_q <= `RST_BUFFER_RAM_BASE;
            segment_q <= `RST_BUFFER_SEGMENT;
        end
        else if (reg_wr)
        begin
            if (be_q[0])
                ram_base_q <= wdata_q[7:0];
            if (be_q[1])
                segment_q <= wdata_q[15:8];
        end
    end

    // Buffer RAM, one byte lane per generate pass; no reset, as RAM
    wire ram_wr = finish && we_q && (tgt_q == TGT_MESSAGE_BUFFER_RAM);
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1)
        begin : g_lane
            always_ff @(posedge clk)
            begin
                if (ram_wr && be_q[lane])
                    message_buffer_ram_q[message_buffer_ram_idx][lane*8 +: 8] <=
                        wdata_q[lane*8 +: 8];
            end
        end
    endgenerate

    // Mapped register bus, driven while the access runs
    wire busy = (st_q == ST_BUSY);
    assign mmr_req = busy && (tgt_q == TGT_MMR);
    assign mmr_addr = addr_q[11:0];
    assign mmr_we = we_q;
    assign mmr_be = be_q;
    assign mmr_wdata = wdata_q;
    assign mmr_msg_obj = (addr_q[11:0] < `MSG_OBJ_LIMIT);
    assign mmr_obj_index = addr_q[8:4];

    // External bus; only A1..A19 leave the chip, so the upper
    // address bits are dropped here
    assign ext_req = busy && (tgt_q == TGT_EXT)
        && !external_access_disable;
    assign ext_addr = addr_q[19:1];
    assign ext_we = we_q;
    assign ext_be = be_q;
    assign ext_wdata = wdata_q;

    // Answers to the masters
    assign core_ack = ack_q && !who_q;
    assign dma_ack = ack_q && who_q;
    assign core_rdata = rdata_q;
    assign dma_rdata = rdata_q;
    assign sfr_rdata = sfr_rdata_q;

    // Checks on the routing, arbitration, answer pulse and external strobe timing
    wire take = (st_q == ST_IDLE) && sel_req;

    AST_MMR_ROUTE: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && regspace_en && (sel_addr[23:12] == regspace_tag)
        |=> (tgt_q == TGT_MMR || tgt_q == TGT_REG))
        else $error("window address not routed to registers");

    AST_MMR_OFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && !regspace_en
        |=> (tgt_q != TGT_MMR && tgt_q != TGT_REG))
        else $error("disabled window still decoded");

    AST_MESSAGE_BUFFER_RAM_ROUTE: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && !mmr_hit && ram_en && (sel_addr[23:9] == ram_tag)
        |=> tgt_q == TGT_MESSAGE_BUFFER_RAM)
        else $error("buffer address not routed to RAM");

    AST_MESSAGE_BUFFER_RAM_OFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && !ram_en |=> tgt_q != TGT_MESSAGE_BUFFER_RAM)
        else $error("disabled buffer RAM still decoded");

    AST_EXT_DEFAULT: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && !mmr_hit && !message_buffer_ram_hit |=> tgt_q == TGT_EXT)
        else $error("unmatched access not sent outside");

    AST_ALTERNATE: assert property (
        @(posedge clk) disable iff (sys_rst)
        take && core_req && dma_req && !core_burst && !last_dma_q
        |=> who_q)
        else $error("DMA not served after core");

    AST_ACK_PULSE: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(ack_q) |-> (st_q == ST_DONE)
        ##1 (!ack_q && st_q == ST_IDLE))
        else $error("answer not a single pulse");

    AST_EXT_MIN: assert property (
        @(posedge clk) disable iff (sys_rst)
        ext_req && (cnt_q < ext_cycles) |=> ext_req)
        else $error("external strobe shorter than programmed");

    AST_EXT_WAIT: assert property (
        @(posedge clk) disable iff (sys_rst)
        ext_req && ext_timed && !wait_state_disable && !ext_ready
        |=> ext_req)
        else $error("wait state not honoured");

endmodule

// File: tb/far_side_model.sv
/*
 * Far-side model: mapped register bus and external memory, both with
 * stall lengths chosen by the bench.
 * Assumes one clock and the decoder's reset shared with the bench.
 */
`timescale 1ns/1ps
module far_side_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stall lengths
    input wire logic [3:0] mmr_delay,
    input wire logic [3:0] ext_stall,
    // Mapped register bus
    input wire logic mmr_req,
    input wire logic [11:0] mmr_addr,
    output logic mmr_ack,
    output logic [15:0] mmr_rdata,
    // External memory
    input wire logic ext_req,
    input wire logic [19:1] ext_addr,
    output logic ext_ready,
    output logic [15:0] ext_rdata
);
    logic [3:0] mcnt_q;
    logic [3:0] ecnt_q;

    // Cycles each request has stood so far
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mcnt_q <= 4'h0;
            ecnt_q <= 4'h0;
        end
        else
        begin
            mcnt_q <= mmr_req ? mcnt_q + 4'h1 : 4'h0;
            ecnt_q <= ext_req ? ecnt_q + 4'h1 : 4'h0;
        end
    end

    // Data inverted outside the answer, so a stale sample shows
    assign mmr_ack = mmr_req && (mcnt_q == mmr_delay);
    assign mmr_rdata = {4'hc, mmr_addr} ^ {16{!mmr_ack}};
    assign ext_ready = (ecnt_q >= ext_stall);
    assign ext_rdata = ext_addr[16:1] ^ {16{!(ext_req && ext_ready)}};
endmodule

// File: tb/tb_mapped_space_decoder.sv
/*
 * Self-checking bench of the mapped space decoder: table of routed
 * accesses, then timing, register, arbitration and reset cases.
 * Assumes the far-side model answers mapped-bus and external cycles.
 */
`timescale 1ns/1ps
`include "mapped_space_params.svh"
module tb_mapped_space_decoder;
    typedef struct {
        bit m;
        logic [23:0] a;
        logic w;
        logic [15:0] d;
        logic [15:0] q;
        logic [1:0] p;
        logic [5:0] o;
    } row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic core_req = 1'b0, core_burst = 1'b0, core_we = 1'b0;
    logic dma_req = 1'b0, dma_we = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [23:0] core_addr = 24'h0, dma_addr = 24'h0;
    logic [15:0] core_wdata = 16'h0, dma_wdata = 16'h0;
    logic [1:0] core_be = 2'h3, dma_be = 2'h3, mmr_be, ext_be;
    logic [10:0] sfr_addr = 11'h0;
    logic [7:0] sfr_wdata = 8'h0, sfr_rdata, rb;
    logic [3:0] ext_cycles = 4'h1, mmr_delay = 4'h0, ext_stall = 4'h0;
    logic core_ack, dma_ack, mmr_req, mmr_we, mmr_msg_obj, mmr_ack;
    logic ext_req, ext_we, ext_ready;
    logic [15:0] core_rdata, dma_rdata, mmr_wdata, mmr_rdata, rd;
    logic [15:0] ext_wdata, ext_rdata;
    logic [11:0] mmr_addr;
    logic [4:0] mmr_obj_index;
    logic [19:1] ext_addr;
    logic [5:0] obj_seen;
    int errors = 0;
    int total_checks = 0;
    int ext_len, mmr_seen;
    bit order [$];
    row_t rows [15] = '{
        '{0, 24'h123010, 0, 16'h0, 16'hc010, 2'b10, 6'h21},
        '{1, 24'h123ffe, 0, 16'h0, 16'hcffe, 2'b10, 6'h1f},
        '{0, 24'h1231f0, 0, 16'h0, 16'hc1f0, 2'b10, 6'h3f},
        '{0, 24'h123200, 0, 16'h0, 16'hc200, 2'b10, 6'h00},
        '{0, 24'h124000, 0, 16'h0, 16'h2000, 2'b01, 6'h0},
        '{0, 24'h122ffe, 0, 16'h0, 16'h17ff, 2'b01, 6'h0},
        '{0, 24'h123290, 0, 16'h0, 16'hfffe, 2'b00, 6'h0},
        '{0, 24'h123290, 1, 16'h0541, 16'hfffe, 2'b00, 6'h0},
        '{0, 24'h123290, 0, 16'h0, 16'h0541, 2'b00, 6'h0},
        '{0, 24'h054002, 1, 16'h1234, 16'h0541, 2'b00, 6'h0},
        '{1, 24'h054002, 0, 16'h0, 16'h1234, 2'b00, 6'h0},
        '{1, 24'h0541fe, 1, 16'hbeef, 16'h1234, 2'b00, 6'h0},
        '{0, 24'h0541fe, 0, 16'h0, 16'hbeef, 2'b00, 6'h0},
        '{0, 24'h054200, 0, 16'h0, 16'ha100, 2'b01, 6'h0},
        '{0, 24'h053ffe, 0, 16'h0, 16'h9fff, 2'b01, 6'h0}};

    mapped_space_decoder dut (.*);
    far_side_model partner (.*);

    always #10 clk = ~clk;

    // Watch the far side and the grant order
    always @(posedge clk)
    begin
        if (ext_req === 1'b1) ext_len++;
        if (mmr_req === 1'b1) mmr_seen++;
        if (mmr_req === 1'b1) obj_seen = {mmr_msg_obj, mmr_obj_index};
        if (core_ack === 1'b1) order.push_back(1'b0);
        if (dma_ack === 1'b1) order.push_back(1'b1);
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic sfr_write(input logic [10:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
        // One idle edge so a following strobe never rises in this step
        @(posedge clk);
        #1;
    endtask

    // Read data stands in the cycle after the strobe
    task automatic sfr_read(input logic [10:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        d = sfr_rdata;
        @(posedge clk);
        #1;
    endtask

    // Request held through the edge that samples the ack
    task automatic access(input bit m, input logic [23:0] a, input logic w,
        input logic [15:0] d, output logic [15:0] q);
        int n;
        ext_len = 0;
        mmr_seen = 0;
        if (m)
        begin
            dma_addr = a;
            dma_we = w;
            dma_wdata = d;
            dma_req = 1'b1;
        end
        else
        begin
            core_addr = a;
            core_we = w;
            core_wdata = d;
            core_req = 1'b1;
        end
        for (n = 0; n < 200 && (m ? dma_ack : core_ack) !== 1'b1; n++)
            @(negedge clk);
        if (n == 200) errors++;
        if (n == 200) test_done();
        q = m ? dma_rdata : core_rdata;
        @(posedge clk);
        #1 if (m) dma_req = 1'b0; else core_req = 1'b0;
        // Idle edge keeps the next request apart from this release
        @(posedge clk);
        #1;
    endtask

    task automatic acc(input bit m, input logic [23:0] a, input logic w,
        input logic [15:0] d, input logic [15:0] eq, input logic [1:0] ep);
        logic [15:0] q;
        access(m, a, w, d, q);
        check(q, eq);
        check({mmr_seen != 0, ext_len != 0}, ep);
    endtask

    // Both masters ask at once; burst keeps the bus with the core
    task automatic race(input logic b, input bit first);
        logic [15:0] q0, q1;
        order.delete();
        core_burst = b;
        fork
            begin
                access(0, 24'h054002, 1'b0, 16'h0, q0);
                core_burst = 1'b0;
            end
            access(1, 24'h0541fe, 1'b0, 16'h0, q1);
        join
        check(24'(order[0]), 24'(first));
        check(q1, 16'hbeef);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        sfr_write(`OFS_REGSPACE_BASE_HIGH, 8'h12);
        sfr_write(`OFS_REGSPACE_BASE_LOW, 8'h31);
        // Row 7 moves the buffer segment below the external limit
        foreach (rows[i])
        begin
            acc(rows[i].m, rows[i].a, rows[i].w, rows[i].d, rows[i].q,
                rows[i].p);
            if (rows[i].p == 2'b10) check(obj_seen, rows[i].o);
        end
        mmr_delay = 4'h3;
        acc(1, 24'h123ffe, 0, 16'h0, 16'hcffe, 2'b10);
        $display("Routing table done");
        // Strobe length, wait input, wait disable, external disable
        ext_cycles = 4'h3;
        for (int k = 0; k < 3; k++)
        begin
            ext_stall = (k == 0) ? 4'h0 : 4'h6;
            if (k == 2) sfr_write(`OFS_MEM_IF_CONTROL, 8'h10);
            access(0, 24'h010000, 1'b0, 16'h0, rd);
            check(24'(ext_len), (k == 1) ? 24'd7 : 24'd4);
        end
        sfr_write(`OFS_MEM_IF_CONTROL, 8'h08);
        acc(0, 24'h010000, 0, 16'h0, 16'h0, 2'b00);
        $display("External timing done");
        sfr_write(`OFS_MEM_IF_CONTROL, 8'hff);
        sfr_read(`OFS_MEM_IF_CONTROL, rb);
        check(rb, 8'h18);
        sfr_read(11'h400, rb);
        check(rb, 8'h00);
        sfr_write(`OFS_MEM_IF_CONTROL, 8'h00);
        acc(0, 24'h054002, 0, 16'h0, 16'h1234, 2'b00);
        race(1'b0, 1'b1);
        race(1'b1, 1'b0);
        $display("Registers and arbitration done");
        // Second reset in mid-run
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        sfr_read(`OFS_REGSPACE_BASE_LOW, rb);
        check(rb, 8'hf0);
        sfr_read(`OFS_REGSPACE_BASE_HIGH, rb);
        check(rb, 8'h0f);
        acc(0, 24'h0ff290, 0, 16'h0, 16'hf948, 2'b01);
        acc(0, 24'hfffe00, 0, 16'h0, 16'hff00, 2'b01);
        sfr_write(`OFS_REGSPACE_BASE_LOW, 8'hf1);
        acc(0, 24'h0ff290, 0, 16'h0, 16'hfffe, 2'b00);
        acc(0, 24'h0ff010, 0, 16'h0, 16'hc010, 2'b10);
        $display("Reset done");
        test_done();
    end
endmodule
